// >>> lgc_pkg.sv
// Behaviour
// - impedance pin low: all receivers high-z
// - impedance pin low: ignore channel termination bits
// - impedance pin high: per-channel termination applies
// - output enable high: drivers follow their driver register bits
// - internal processing unaffected by output enable
// - enable pin open: global pin sets mode
// - enable pin low: per-channel bit sets mode
// - global pin low E1, open T1/J1
// - enable pin low: global mode pin ignored
// - common-mode outputs only while enable high
package lgc_pkg;

  localparam int          LGC_NCH          = 16;
  localparam int          LGC_TERM_W       = 3;
  // apb register offsets (byte addresses)
  localparam logic [11:0] LGC_OFF_STATUS   = 12'h000;
  localparam logic [11:0] LGC_OFF_MODE     = 12'h004;
  localparam logic [11:0] LGC_OFF_DRV      = 12'h008;
  localparam logic [11:0] LGC_OFF_REFCNT   = 12'h00C;
  localparam logic [11:0] LGC_OFF_CH_BASE  = 12'h040;
  // channel config field positions
  localparam int          LGC_CH_STD_BIT   = 0;
  localparam int          LGC_CH_TERM_LSB  = 0;
  localparam int          LGC_CH_R120_BIT  = 4;
  // status field positions
  localparam int          LGC_ST_RXIMP     = 0;
  localparam int          LGC_ST_OE        = 1;
  localparam int          LGC_ST_STDEN     = 2;
  localparam int          LGC_ST_STD       = 3;
  localparam int          LGC_ST_CMEN      = 4;
  // reset values
  localparam logic [7:0]  LGC_CH_RST       = 8'h00;
  localparam logic [15:0] LGC_MODE_RST     = 16'h0000;
  localparam logic [15:0] LGC_DRV_RST      = 16'hFFFF;
  // line standard encoding: 1 = t1/j1, 0 = e1
  localparam logic        LGC_STD_T1       = 1'b1;
  localparam logic        LGC_STD_E1       = 1'b0;

endpackage : lgc_pkg

// >>> lgc_sync2.sv
`timescale 1ns/10ps
// two-flop synchroniser for one pin level
module lgc_sync2
  import lgc_pkg::*;
#(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;  // first stage, read only by second stage
  logic sync_q;  // second stage

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule // lgc_sync2

// >>> lgc_edge_cnt.sv
`timescale 1ns/10ps
// counts rising edges of a synchronised reference clock level
module lgc_edge_cnt
  import lgc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        level_in,
  input  wire logic        clr,
  output logic [15:0]      count
);

  logic        prev_q;   // last level seen
  logic        prev_d;
  logic [15:0] cnt_q;    // edge count, wraps
  logic [15:0] cnt_d;

  // next-state: rising edge bumps the count, clear wins over an edge in the same cycle
  always_comb begin
    prev_d = level_in;
    cnt_d  = cnt_q;
    if (clr) begin
      cnt_d = 16'h0000;
    end else if (level_in && !prev_q) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
      cnt_q  <= 16'h0000;
    end else begin
      prev_q <= prev_d;
      cnt_q  <= cnt_d;
    end
  end

  assign count = cnt_q;

endmodule // lgc_edge_cnt

// >>> lgc_top.sv
`timescale 1ns/10ps
// global pin control of a 16-channel line interface, apb slave
module lgc_top
  import lgc_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // apb slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  // global pins (already resolved: open pins arrive high)
  input  wire logic                  rx_impedance_global_sel,
  input  wire logic                  glob_out_enable,
  input  wire logic                  hw_line_std_sel_enable,
  input  wire logic                  hw_line_std_sel,
  input  wire logic                  common_mode_out_enable,
  input  wire logic                  ext_ref_clock_a,
  input  wire logic                  ext_ref_clock_b,
  // per-channel results
  output logic [LGC_NCH-1:0]         rx_term_enable,
  output logic [LGC_NCH*LGC_TERM_W-1:0] rx_term_sel,
  output logic [LGC_NCH-1:0]         rx_term_120ohm,
  output logic [LGC_NCH-1:0]         tx_driver_enable,
  output logic [LGC_NCH-1:0]         chan_is_t1,
  output logic [1:0]                 common_mode_voltage_out
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic rximp_s;   // receive impedance pin
  logic oe_s;      // global output enable
  logic stden_s;   // hw line standard enable
  logic std_s;     // hw line standard
  logic cmen_s;    // common-mode enable
  logic refa_s;    // reference clock a level
  logic refb_s;    // reference clock b level

  // every pin crosses two flops before any logic reads it; reset levels
  // follow the idle or pulled level of each pin
  // receive impedance pin, low until the first samples arrive
  lgc_sync2 #(.RST_VAL(1'b0)) u_s_rximp (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (rx_impedance_global_sel),
    .sync_out (rximp_s)
  );
  // global output enable: drivers stay off until it is seen high
  lgc_sync2 #(.RST_VAL(1'b0)) u_s_oe (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (glob_out_enable),
    .sync_out (oe_s)
  );
  // line standard enable, reset high like an open pulled-up pin
  lgc_sync2 #(.RST_VAL(1'b1)) u_s_stden (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hw_line_std_sel_enable),
    .sync_out (stden_s)
  );
  // line standard pin, reset high: t1/j1 as an open pin selects
  lgc_sync2 #(.RST_VAL(1'b1)) u_s_std (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (hw_line_std_sel),
    .sync_out (std_s)
  );
  // common-mode enable, reset low like its pull-down
  lgc_sync2 #(.RST_VAL(1'b0)) u_s_cmen (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (common_mode_out_enable),
    .sync_out (cmen_s)
  );
  // reference clock a level, fed to its edge counter
  lgc_sync2 #(.RST_VAL(1'b0)) u_s_refa (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_ref_clock_a),
    .sync_out (refa_s)
  );
  // reference clock b level, fed to its edge counter
  lgc_sync2 #(.RST_VAL(1'b0)) u_s_refb (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (ext_ref_clock_b),
    .sync_out (refb_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // reference clock activity counters
  logic [15:0] cnt_a;   // edges seen on reference a
  logic [15:0] cnt_b;   // edges seen on reference b
  logic        cnt_clr; // write to counter register clears both

  // inputs carry 1.544 or 2.048 mhz, unused tied low
  // a count that stays still shows a missing or tied-off reference
  lgc_edge_cnt u_cnt_a (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (refa_s),
    .clr      (cnt_clr),
    .count    (cnt_a)
  );
  // second reference counter, cleared together with the first
  lgc_edge_cnt u_cnt_b (
    .pclk     (pclk),
    .presetn  (presetn),
    .level_in (refb_s),
    .clr      (cnt_clr),
    .count    (cnt_b)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file
  logic [7:0]  ch_cfg_q [LGC_NCH];  // per-channel config word
  logic [7:0]  ch_cfg_d [LGC_NCH];
  logic [15:0] mode_q;              // per-channel line standard bits
  logic [15:0] mode_d;
  logic [15:0] drv_q;               // per-channel driver enables
  logic [15:0] drv_d;
  logic [31:0] prdata_q;            // read data
  logic [31:0] prdata_d;
  logic        pslverr_q;           // error answer
  logic        pslverr_d;

  // bus decode helpers
  logic        wr_en;               // access phase write
  logic        rd_en;               // access phase read
  logic        ch_hit;              // address in channel window
  logic [3:0]  ch_idx;              // channel index from address
  logic [4:0]  status;              // synchronised pin levels

  // strobes of the access phase, one per direction
  assign wr_en  = psel && penable && pwrite;
  assign rd_en  = psel && penable && !pwrite;
  // channel window: sixteen aligned words from the channel base
  assign ch_hit = (paddr >= LGC_OFF_CH_BASE) &&
                  (paddr <  LGC_OFF_CH_BASE + 12'h040) &&
                  (paddr[1:0] == 2'b00);
  assign ch_idx = paddr[5:2];
  assign cnt_clr = wr_en && (paddr == LGC_OFF_REFCNT);

  // pin levels as software reads them in the status word
  always_comb begin
    status               = 5'h00;
    status[LGC_ST_RXIMP] = rximp_s;
    status[LGC_ST_OE]    = oe_s;
    status[LGC_ST_STDEN] = stden_s;
    status[LGC_ST_STD]   = std_s;
    status[LGC_ST_CMEN]  = cmen_s;
  end

  // next-state: writes and read data; zero-wait answer
  // the setup cycle prepares prdata and pslverr so both leave flops
  always_comb begin
    for (int i = 0; i < LGC_NCH; i++) begin
      ch_cfg_d[i] = ch_cfg_q[i];
    end
    mode_d    = mode_q;
    drv_d     = drv_q;
    prdata_d  = prdata_q;
    pslverr_d = 1'b0;
    if (psel && !penable) begin
      // setup cycle: prepare answer for the access phase
      prdata_d  = 32'h0000_0000;
      if (pwrite) begin
        pslverr_d = 1'b0;
        if (!(paddr == LGC_OFF_MODE || paddr == LGC_OFF_DRV ||
              paddr == LGC_OFF_REFCNT || ch_hit)) begin
          pslverr_d = 1'b1;  // unmapped or read-only
        end
      end else if (paddr == LGC_OFF_STATUS) begin
        prdata_d = {27'h0, status};
      end else if (paddr == LGC_OFF_MODE) begin
        prdata_d = {16'h0, mode_q};
      end else if (paddr == LGC_OFF_DRV) begin
        prdata_d = {16'h0, drv_q};
      end else if (paddr == LGC_OFF_REFCNT) begin
        prdata_d = {cnt_b, cnt_a};
      end else if (ch_hit) begin
        prdata_d = {24'h0, ch_cfg_q[ch_idx]};
      end else begin
        pslverr_d = 1'b1;   // unmapped read
      end
    end else if (wr_en || rd_en) begin
      // access phase: the error answer set up one cycle earlier holds
      pslverr_d = pslverr_q;
    end
    // writes land at the access edge; read-only and unmapped addresses
    // leave every register untouched
    if (wr_en) begin
      if (paddr == LGC_OFF_MODE) begin
        mode_d = pwdata[15:0];
      end else if (paddr == LGC_OFF_DRV) begin
        drv_d = pwdata[15:0];
      end else if (ch_hit) begin
        ch_cfg_d[ch_idx] = pwdata[7:0];
      end
    end
  end

  // registers only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < LGC_NCH; i++) begin
        ch_cfg_q[i] <= LGC_CH_RST;
      end
      mode_q    <= LGC_MODE_RST;
      drv_q     <= LGC_DRV_RST;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      for (int i = 0; i < LGC_NCH; i++) begin
        ch_cfg_q[i] <= ch_cfg_d[i];
      end
      mode_q    <= mode_d;
      drv_q     <= drv_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  logic rdy_q;  // constant-high ready from a flip-flop

  // answer flops drive the bus outputs directly
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;
  assign pready  = rdy_q;

  // ready rises at the first edge after reset and stays high, so an
  // access phase always lasts one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global pin resolution into per-channel outputs
  logic [LGC_NCH-1:0]            term_en_d;
  logic [LGC_NCH*LGC_TERM_W-1:0] term_sel_d;
  logic [LGC_NCH-1:0]            r120_d;
  logic [LGC_NCH-1:0]            txen_d;
  logic [LGC_NCH-1:0]            t1_d;
  logic [1:0]                    cm_d;

  // next values of the per-channel outputs; one more flop after this
  // keeps decode glitches off the outputs
  always_comb begin
    for (int i = 0; i < LGC_NCH; i++) begin
      if (!rximp_s) begin
        // all receivers high-z, channel bits ignored
        term_en_d[i] = 1'b0;
        term_sel_d[i*LGC_TERM_W +: LGC_TERM_W] = 3'h0;
        r120_d[i] = 1'b0;
      end else begin
        term_en_d[i] = 1'b1;
        term_sel_d[i*LGC_TERM_W +: LGC_TERM_W] =
          ch_cfg_q[i][LGC_CH_TERM_LSB +: LGC_TERM_W];
        r120_d[i] = ch_cfg_q[i][LGC_CH_R120_BIT];
      end
      // pin gates only the drivers; register state untouched
      txen_d[i] = oe_s && drv_q[i];
      if (stden_s) begin
        // open (high) enable: global pin, low = e1, open = t1
        t1_d[i] = std_s ? LGC_STD_T1 : LGC_STD_E1;
      end else begin
        // per-channel bit; global pin disregarded
        t1_d[i] = mode_q[i];
      end
    end
    cm_d = {2{cmen_s}};
  end

  // registers only
  // reset levels: receivers high-z, drivers off, t1/j1 as the
  // pulled-up straps would select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_term_enable          <= '0;
      rx_term_sel             <= '0;
      rx_term_120ohm          <= '0;
      tx_driver_enable        <= '0;
      chan_is_t1              <= '1;
      common_mode_voltage_out <= 2'h0;
    end else begin
      rx_term_enable          <= term_en_d;
      rx_term_sel             <= term_sel_d;
      rx_term_120ohm          <= r120_d;
      tx_driver_enable        <= txen_d;
      chan_is_t1              <= t1_d;
      common_mode_voltage_out <= cm_d;
    end
  end

endmodule // lgc_top

// >>> lgc_board.sv
`timescale 1ns/10ps
// board straps and reference oscillators around the block
module lgc_board (
  input  wire logic imp_lvl,
  input  wire logic oe_lvl,
  input  wire logic en_open,
  input  wire logic std_open,
  input  wire logic cm_lvl,
  input  wire logic ca_on,
  input  wire logic cb_on,
  output logic      imp_pin,
  output logic      oe_pin,
  output logic      en_pin,
  output logic      std_pin,
  output logic      cm_pin,
  output logic      ref_a,
  output logic      ref_b
);
  logic osc_a = 1'b0; // t1/j1 oscillator
  logic osc_b = 1'b0; // e1 oscillator
  always #323.83 osc_a = ~osc_a;
  always #244.14 osc_b = ~osc_b;
  // open straps read high through the pull-ups
  assign en_pin  = en_open ? 1'b1 : 1'b0;
  assign std_pin = std_open ? 1'b1 : 1'b0;
  assign imp_pin = imp_lvl;
  assign oe_pin  = oe_lvl;
  assign cm_pin  = cm_lvl;
  // an unused reference input is tied low
  assign ref_a   = ca_on & osc_a;
  assign ref_b   = cb_on & osc_b;
endmodule // lgc_board

// >>> lgc_checker.sv
`timescale 1ns/10ps
// pin-to-output relations seen at the top ports
module lgc_checker
  import lgc_pkg::*;
(
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pready,
  input wire logic                    rx_impedance_global_sel,
  input wire logic                    glob_out_enable,
  input wire logic                    hw_line_std_sel_enable,
  input wire logic                    hw_line_std_sel,
  input wire logic                    common_mode_out_enable,
  input wire logic [LGC_NCH-1:0]      rx_term_enable,
  input wire logic [LGC_NCH*3-1:0]    rx_term_sel,
  input wire logic [LGC_NCH-1:0]      rx_term_120ohm,
  input wire logic [LGC_NCH-1:0]      tx_driver_enable,
  input wire logic [LGC_NCH-1:0]      chan_is_t1,
  input wire logic [1:0]              common_mode_voltage_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // levels held long enough to cross the synchroniser
  sequence imp_lo; (!rx_impedance_global_sel)[*5]; endsequence
  sequence imp_hi; rx_impedance_global_sel[*5]; endsequence
  sequence hw_t1; (hw_line_std_sel_enable && hw_line_std_sel)[*5];
  endsequence
  sequence hw_e1; (hw_line_std_sel_enable && !hw_line_std_sel)[*5];
  endsequence
  a_rx_all_hiz: assert property (imp_lo |-> rx_term_enable == '0)
    else $error("receivers not high-z");
  a_term_ignored: assert property (imp_lo |->
    rx_term_sel == '0 && rx_term_120ohm == '0) else $error("term used");
  a_term_allowed: assert property (imp_hi |-> rx_term_enable == '1)
    else $error("termination blocked");
  a_drv_forced_off: assert property ((!glob_out_enable)[*5] |->
    tx_driver_enable == '0) else $error("driver on with oe low");
  a_std_hw_t1: assert property (hw_t1 |-> chan_is_t1 == '1)
    else $error("global t1 not applied");
  a_std_hw_e1: assert property (hw_e1 |-> chan_is_t1 == '0)
    else $error("global e1 not applied");
  a_cm_on: assert property (common_mode_out_enable[*5] |->
    common_mode_voltage_out == 2'h3) else $error("common mode off");
  a_cm_off: assert property ((!common_mode_out_enable)[*5] |->
    common_mode_voltage_out == 2'h0) else $error("common mode on");
  a_pready_access: assert property (psel && penable |-> pready)
    else $error("no pready in access");
endmodule // lgc_checker

bind lgc_top lgc_checker lgc_checker_inst (.pclk, .presetn, .psel,
  .penable, .pready, .rx_impedance_global_sel, .glob_out_enable,
  .hw_line_std_sel_enable, .hw_line_std_sel, .common_mode_out_enable,
  .rx_term_enable, .rx_term_sel, .rx_term_120ohm, .tx_driver_enable,
  .chan_is_t1, .common_mode_voltage_out);

// >>> tb_top.sv
`timescale 1ns/10ps
// self-checking bench for the global pin control block
module tb_top;
  import lgc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er;
  logic imp = 1, oe = 1, en_o = 1, std_o = 1, cm = 0, ca = 0, cb = 0;
  logic imp_p, oe_p, en_p, std_p, cm_p, ra, rb;
  logic [15:0] rte, r120, txe, t1;
  logic [47:0] rts;
  logic [1:0] cmv;
  int err_count = 0, compares = 0;
  always #12.5 pclk = ~pclk; // 40 MHz
  lgc_board lgc_board_inst (.imp_lvl(imp), .oe_lvl(oe), .en_open(en_o),
    .std_open(std_o), .cm_lvl(cm), .ca_on(ca), .cb_on(cb),
    .imp_pin(imp_p), .oe_pin(oe_p), .en_pin(en_p), .std_pin(std_p),
    .cm_pin(cm_p), .ref_a(ra), .ref_b(rb));
  lgc_top lgc_top_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr,
    .rx_impedance_global_sel(imp_p), .glob_out_enable(oe_p),
    .hw_line_std_sel_enable(en_p), .hw_line_std_sel(std_p),
    .common_mode_out_enable(cm_p), .ext_ref_clock_a(ra),
    .ext_ref_clock_b(rb), .rx_term_enable(rte), .rx_term_sel(rts),
    .rx_term_120ohm(r120), .tx_driver_enable(txe), .chan_is_t1(t1),
    .common_mode_voltage_out(cmv));
  ////////////////////////////////////////////////////////////////////
  // apb cycle: setup, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // compare one value, count it, report a mismatch
  task automatic check(input logic [47:0] got, exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // let a pin change cross the synchroniser
  task automatic settle;
    repeat (5) @(posedge pclk);
    #1;
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // reset values and pin status
  task automatic t_reset;
    apb(0, LGC_OFF_DRV, 0);  check(rd, 32'h0000FFFF);
    apb(0, LGC_OFF_MODE, 0); check(rd, 32'h0);
    apb(0, 12'h040, 0);      check(rd, 32'h0);
    apb(0, LGC_OFF_STATUS, 0); check(rd, 32'h0000000F);
  endtask
  // per-channel termination gated by the impedance pin
  task automatic t_term;
    apb(1, 12'h04C, 32'h15);
    @(posedge pclk); imp <= 1; settle;
    check({rte, r120}, 32'hFFFF0008);
    check(rts, 48'h000000000A00);
    @(posedge pclk); imp <= 0; settle;
    check({rte, r120}, 0);
    check(rts, 0);
    apb(0, 12'h04C, 0); check(rd, 32'h15);
    @(posedge pclk); imp <= 1;
  endtask
  // global driver enable over the driver register
  task automatic t_drv;
    apb(1, LGC_OFF_DRV, 32'hF0); settle;
    check(txe, 16'h00F0);
    @(posedge pclk); oe <= 0; settle;
    check(txe, 0);
    apb(0, LGC_OFF_DRV, 0); check(rd, 32'hF0);
    @(posedge pclk); oe <= 1; settle;
    check(txe, 16'h00F0);
  endtask
  // line standard: global straps, then per channel
  task automatic t_std;
    check(t1, 16'hFFFF);
    @(posedge pclk); std_o <= 0; settle;
    check(t1, 0);
    apb(1, LGC_OFF_MODE, 32'hA5A5);
    @(posedge pclk); en_o <= 0; settle;
    check(t1, 16'hA5A5);
    @(posedge pclk); std_o <= 1; settle;
    check(t1, 16'hA5A5);
  endtask
  // common-mode outputs follow their enable
  task automatic t_cm;
    @(posedge pclk); cm <= 1; settle; check(cmv, 2'h3);
    @(posedge pclk); cm <= 0; settle; check(cmv, 2'h0);
  endtask
  // reference a runs, b tied low; unmapped and read-only refused
  task automatic t_misc;
    apb(1, LGC_OFF_REFCNT, 0);
    @(posedge pclk); ca <= 1;
    repeat (1000) @(posedge pclk);
    ca <= 0; settle;
    apb(0, LGC_OFF_REFCNT, 0);
    check(rd[31:16], 0);
    check(rd[15:0] > 36 && rd[15:0] < 41, 1);
    apb(0, 12'h020, 0); check({er, rd}, 33'h100000000);
    apb(1, LGC_OFF_STATUS, 0); check(er, 1);
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    settle;
    t_reset; t_term; t_drv; t_std; t_cm; t_misc;
    stop_test;
  end
  // watchdog
  initial begin
    #200000;
    err_count++;
    stop_test;
  end
endmodule // tb_top
